// ===== design/scr_router.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1: Request output high while D data waits; the code keeps it low in D_HOLD until pending drops.
// R2: Transceiver grants when D channel free.
// R3: Grant sampled only at frame sync.
// R4: Granted frame starts with flag zero bit.
// R5: Transceiver drops grant on collision.
// R6: Collision stops sending, frame resent later.
// R7: Automatic resend only within first two buffers.
// R8: B2 steer 0 strobe two, 1 one.
// R9: B1 steer 0 strobe one, 1 two.
// R10: B2 route code decode to controllers.
// R11: B1 route code decode to controllers.
// R12: D route code decode to controllers.
// R13: Third connect bit chooses mux or pins.
// R14: Second connect bit chooses mux or pins.
// R15: Mode 00 puts controller one on pins.
// R16: Direct mode port A carries controller functions.
// R17: Maintenance to management one, auxiliary to two.
// R18: Sync pulse starts twenty bit frame.
// R19: Transmit data driven only on supported bits.
// R20: Both B channels may share one controller.
// R21: Frame holds B, D, M, A channel rates.
module scr_router (
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  input wire logic LINE_CLK_I,
  input wire logic LINE_FRAME_SYNC_I,
  input wire logic LINE_RECEIVE_DATA_I,
  output logic LINE_TRANSMIT_DATA_O,
  output logic LINE_TRANSMIT_DATA_OE_O,
  output logic D_CHANNEL_REQUEST_O,
  input wire logic D_CHANNEL_GRANT_I,
  output logic STROBE_ONE_O,
  output logic STROBE_TWO_O,
  input wire logic [1:0] INTERFACE_MODE_SELECT_I,
  input wire logic SECOND_CONTROLLER_CONNECT_I,
  input wire logic THIRD_CONTROLLER_CONNECT_I,
  input wire logic [1:0] D_ROUTE_FIELD_I,
  input wire logic [1:0] B1_ROUTE_FIELD_I,
  input wire logic [1:0] B2_ROUTE_FIELD_I,
  input wire logic B1_STROBE_STEER_I,
  input wire logic B2_STROBE_STEER_I,
  input wire logic PORT_A_SER2_SEL_I,
  input wire logic PORT_A_SER3_SEL_I,
  input wire logic D_TX_PENDING_I,
  input wire logic D_TX_EARLY_BUF_I,
  output logic D_RETRANSMIT_O,
  output logic D_ABORT_O,
  output logic SER1_DIRECT_O,
  output logic PORT_A_SER2_O,
  output logic PORT_A_SER3_O,
  input wire logic [2:0] SER_TXD_I,
  output logic [2:0] SER_TX_STB_O,
  output logic [2:0] SER_RX_STB_O,
  input wire logic [1:0] MGMT_TXD_I,
  output logic [1:0] MGMT_TX_STB_O,
  output logic [1:0] MGMT_RX_STB_O,
  output logic RX_BIT_O
);

  // ****************************************
  // Master clock side
  // ****************************************
  logic [11:0] cfg_r;
  logic pend_m_r;
  logic early_m_r;
  logic [2:0] retx_s_r;
  logic [2:0] abort_s_r;
  logic retx_tgl_r;
  logic abort_tgl_r;

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cfg_r <= scr_pkg::CFG_RST;
      pend_m_r <= 1'b0;
      early_m_r <= 1'b0;
    end else begin
      cfg_r <= {B2_STROBE_STEER_I, B1_STROBE_STEER_I, B2_ROUTE_FIELD_I, B1_ROUTE_FIELD_I,
                D_ROUTE_FIELD_I, THIRD_CONTROLLER_CONNECT_I, SECOND_CONTROLLER_CONNECT_I,
                INTERFACE_MODE_SELECT_I};
      pend_m_r <= D_TX_PENDING_I;
      early_m_r <= D_TX_EARLY_BUF_I;
    end
  end

  // Pin assignment of the controllers
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      SER1_DIRECT_O <= 1'b0;
      PORT_A_SER2_O <= 1'b0;
      PORT_A_SER3_O <= 1'b0;
    end else begin
      // R15: controller one on pins
      SER1_DIRECT_O <= INTERFACE_MODE_SELECT_I == scr_pkg::MODE_DIRECT;
      // R14: R16: controller two pins
      PORT_A_SER2_O <= SECOND_CONTROLLER_CONNECT_I & PORT_A_SER2_SEL_I;
      // R13: R16: controller three pins
      PORT_A_SER3_O <= THIRD_CONTROLLER_CONNECT_I & PORT_A_SER3_SEL_I;
    end
  end

  // Event toggles from the line side
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      retx_s_r <= 3'h0;
      abort_s_r <= 3'h0;
      D_RETRANSMIT_O <= 1'b0;
      D_ABORT_O <= 1'b0;
    end else begin
      retx_s_r <= {retx_s_r[1:0], retx_tgl_r};
      abort_s_r <= {abort_s_r[1:0], abort_tgl_r};
      // R6: restart pulse to controller
      D_RETRANSMIT_O <= retx_s_r[2] ^ retx_s_r[1];
      D_ABORT_O <= abort_s_r[2] ^ abort_s_r[1];
    end
  end

  // ****************************************
  // Line clock side
  // ****************************************
  logic [13:0] x_s1_r;
  logic [13:0] x_s2_r;
  logic [13:0] x_s3_r;
  logic [13:0] x_hold_r;
  logic [11:0] l_cfg;
  logic pend_l;
  logic early_l;
  logic [4:0] cnt_r;
  logic [4:0] pos;
  scr_pkg::scr_slot_type slot;
  logic [4:0] own;
  logic [4:0] rx_own;
  scr_pkg::scr_dstate_type d_state_r;
  scr_pkg::scr_dstate_type d_nxt;
  logic [3:0] flag_cnt_r;
  logic tx_nxt;
  logic tx_oe_nxt;
  logic [2:0] ser_stb_nxt;
  logic [1:0] mgmt_stb_nxt;

  // Configuration and pending levels are quasi static
  always_ff @(posedge LINE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      x_s1_r <= 14'h0000;
      x_s2_r <= 14'h0000;
      x_s3_r <= 14'h0000;
      x_hold_r <= 14'h0000;
    end else begin
      x_s1_r <= {early_m_r, pend_m_r, cfg_r};
      x_s2_r <= x_s1_r;
      x_s3_r <= x_s2_r;
      // Word taken only when two samples agree, so bit skew never leaks through
      if (x_s2_r == x_s3_r) x_hold_r <= x_s2_r;
    end
  end

  assign l_cfg = x_hold_r[11:0];
  assign pend_l = x_hold_r[12];
  assign early_l = x_hold_r[13];

  // Channel ownership of a bit slot
  function automatic logic [4:0] owner(input scr_pkg::scr_slot_type s, input logic [11:0] c);
    logic m;
    logic [4:0] o;
    m = c[scr_pkg::CFG_MODE +: 2] != scr_pkg::MODE_DIRECT;
    o = 5'h00;
    unique case (s)
      // R11: R20: B1 route decode
      scr_pkg::SL_B1: o = {2'h0, scr_pkg::route_onehot(c[scr_pkg::CFG_B1 +: 2],
                                 c[scr_pkg::CFG_C2], c[scr_pkg::CFG_C3], m)};
      // R10: R20: B2 route decode
      scr_pkg::SL_B2: o = {2'h0, scr_pkg::route_onehot(c[scr_pkg::CFG_B2 +: 2],
                                 c[scr_pkg::CFG_C2], c[scr_pkg::CFG_C3], m)};
      // R12: D route decode
      scr_pkg::SL_D: o = {2'h0, scr_pkg::route_onehot(c[scr_pkg::CFG_D +: 2],
                                c[scr_pkg::CFG_C2], c[scr_pkg::CFG_C3], m)};
      // R17: fixed management routes
      scr_pkg::SL_MAINT: o = {1'b0, m, 3'h0};
      scr_pkg::SL_AUX: o = {m, 4'h0};
      scr_pkg::SL_NONE: o = 5'h00;
    endcase
    return o;
  endfunction

  // R18: frame position from sync
  always_comb begin
    pos = scr_pkg::FRAME_BITS;
    if (LINE_FRAME_SYNC_I) pos = 5'h00;
    else if (cnt_r != scr_pkg::FRAME_BITS) pos = cnt_r + 5'h01;
  end

  always_ff @(posedge LINE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) cnt_r <= scr_pkg::FRAME_BITS;
    else cnt_r <= pos;
  end

  // R21: slot layout of the frame
  assign slot = scr_pkg::slot_of(pos);
  assign own = owner(slot, l_cfg);
  assign rx_own = owner(scr_pkg::slot_of(cnt_r), l_cfg);

  // D channel contention
  always_comb begin
    d_nxt = d_state_r;
    unique case (d_state_r)
      scr_pkg::D_IDLE: if (pend_l) d_nxt = scr_pkg::D_REQ;
      scr_pkg::D_REQ: begin
        if (!pend_l) d_nxt = scr_pkg::D_IDLE;
        // R2: R3: grant looked at on sync
        else if (LINE_FRAME_SYNC_I && D_CHANNEL_GRANT_I) d_nxt = scr_pkg::D_SEND;
      end
      scr_pkg::D_SEND: begin
        if (!pend_l) d_nxt = scr_pkg::D_IDLE;
        // R5: R6: R7: collision handling
        else if (LINE_FRAME_SYNC_I && !D_CHANNEL_GRANT_I)
          d_nxt = early_l ? scr_pkg::D_REQ : scr_pkg::D_HOLD;
      end
      scr_pkg::D_HOLD: if (!pend_l) d_nxt = scr_pkg::D_IDLE;
    endcase
  end

  always_ff @(posedge LINE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      d_state_r <= scr_pkg::D_IDLE;
      D_CHANNEL_REQUEST_O <= 1'b0;
    end else begin
      d_state_r <= d_nxt;
      // R1: request while data waits in D_REQ or D_SEND
      D_CHANNEL_REQUEST_O <= d_nxt == scr_pkg::D_REQ || d_nxt == scr_pkg::D_SEND;
    end
  end

  always_ff @(posedge LINE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      retx_tgl_r <= 1'b0;
      abort_tgl_r <= 1'b0;
    end else if (d_state_r == scr_pkg::D_SEND) begin
      // R6: R7: tell controller to rewind (D_REQ) or abort (D_HOLD)
      if (d_nxt == scr_pkg::D_REQ) retx_tgl_r <= ~retx_tgl_r;
      if (d_nxt == scr_pkg::D_HOLD) abort_tgl_r <= ~abort_tgl_r;
    end
  end

  // R4: opening flag restarts each attempt
  always_ff @(posedge LINE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) flag_cnt_r <= 4'h0;
    else if (d_state_r != scr_pkg::D_SEND) flag_cnt_r <= 4'h0;
    else if (slot == scr_pkg::SL_D && own[2:0] != 3'h0 && flag_cnt_r < scr_pkg::FLAG_BITS)
      flag_cnt_r <= flag_cnt_r + 4'h1;
  end

  // Transmit bit selection
  always_comb begin
    tx_nxt = 1'b1;
    tx_oe_nxt = 1'b0;
    ser_stb_nxt = 3'h0;
    mgmt_stb_nxt = 2'h0;
    unique case (slot)
      scr_pkg::SL_B1, scr_pkg::SL_B2: begin
        tx_oe_nxt = |own[2:0];
        tx_nxt = |(SER_TXD_I & own[2:0]);
        ser_stb_nxt = own[2:0];
      end
      scr_pkg::SL_D: begin
        if (d_state_r == scr_pkg::D_SEND && own[2:0] != 3'h0) begin
          tx_oe_nxt = 1'b1;
          // R4: flag bits lead, zero first
          if (flag_cnt_r < scr_pkg::FLAG_BITS) begin
            tx_nxt = scr_pkg::OPEN_FLAG[flag_cnt_r[2:0]];
          end else begin
            tx_nxt = |(SER_TXD_I & own[2:0]);
            ser_stb_nxt = own[2:0];
          end
        end
      end
      scr_pkg::SL_MAINT, scr_pkg::SL_AUX: begin
        tx_oe_nxt = |own[4:3];
        tx_nxt = |(MGMT_TXD_I & own[4:3]);
        mgmt_stb_nxt = own[4:3];
      end
      scr_pkg::SL_NONE: tx_oe_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge LINE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      LINE_TRANSMIT_DATA_O <= 1'b1;
      LINE_TRANSMIT_DATA_OE_O <= 1'b0;
      SER_TX_STB_O <= 3'h0;
      MGMT_TX_STB_O <= 2'h0;
    end else begin
      LINE_TRANSMIT_DATA_O <= tx_nxt;
      // R19: drive only supported bits
      LINE_TRANSMIT_DATA_OE_O <= tx_oe_nxt;
      SER_TX_STB_O <= ser_stb_nxt;
      MGMT_TX_STB_O <= mgmt_stb_nxt;
    end
  end

  // Receive bit of the previous period
  always_ff @(posedge LINE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      RX_BIT_O <= 1'b1;
      SER_RX_STB_O <= 3'h0;
      MGMT_RX_STB_O <= 2'h0;
    end else begin
      RX_BIT_O <= LINE_RECEIVE_DATA_I;
      SER_RX_STB_O <= rx_own[2:0];
      MGMT_RX_STB_O <= rx_own[4:3];
    end
  end

  always_ff @(posedge LINE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      STROBE_ONE_O <= 1'b0;
      STROBE_TWO_O <= 1'b0;
    end else begin
      // R8: R9: strobe steering
      STROBE_ONE_O <= (slot == scr_pkg::SL_B1 && !l_cfg[scr_pkg::CFG_S1]) ||
                      (slot == scr_pkg::SL_B2 && l_cfg[scr_pkg::CFG_S2]);
      STROBE_TWO_O <= (slot == scr_pkg::SL_B1 && l_cfg[scr_pkg::CFG_S1]) ||
                      (slot == scr_pkg::SL_B2 && !l_cfg[scr_pkg::CFG_S2]);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_req_rise;
    @(posedge LINE_CLK_I) disable iff (!RESET_N_I)
    (d_state_r == scr_pkg::D_IDLE && pend_l) |=> D_CHANNEL_REQUEST_O;
  endproperty
  a_req_rise: assert property (p_req_rise) else $error("request not raised"); // R1

  property p_grant_at_sync;
    @(posedge LINE_CLK_I) disable iff (!RESET_N_I)
    (d_state_r == scr_pkg::D_REQ && !LINE_FRAME_SYNC_I) |=> d_state_r != scr_pkg::D_SEND;
  endproperty
  a_grant_at_sync: assert property (p_grant_at_sync) else $error("grant used off sync"); // R3

  property p_flag_zero;
    @(posedge LINE_CLK_I) disable iff (!RESET_N_I)
    (pos == scr_pkg::D_FIRST && d_state_r == scr_pkg::D_SEND && flag_cnt_r == 4'h0 && own != 5'h00)
    |=> LINE_TRANSMIT_DATA_OE_O && !LINE_TRANSMIT_DATA_O;
  endproperty
  a_flag_zero: assert property (p_flag_zero) else $error("flag zero missing"); // R4

  property p_retry;
    @(posedge LINE_CLK_I) disable iff (!RESET_N_I)
    (d_state_r == scr_pkg::D_SEND && pend_l && early_l && LINE_FRAME_SYNC_I && !D_CHANNEL_GRANT_I)
    |=> d_state_r == scr_pkg::D_REQ && D_CHANNEL_REQUEST_O;
  endproperty
  a_retry: assert property (p_retry) else $error("no retry on collision"); // R6

  property p_no_retry;
    @(posedge LINE_CLK_I) disable iff (!RESET_N_I)
    (d_state_r == scr_pkg::D_SEND && pend_l && !early_l && LINE_FRAME_SYNC_I && !D_CHANNEL_GRANT_I)
    |=> !D_CHANNEL_REQUEST_O ##1 !D_CHANNEL_REQUEST_O;
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("late collision retried"); // R7

  property p_b2_strobe;
    @(posedge LINE_CLK_I) disable iff (!RESET_N_I)
    slot == scr_pkg::SL_B2 |=> STROBE_ONE_O == $past(l_cfg[scr_pkg::CFG_S2]) && STROBE_TWO_O != STROBE_ONE_O;
  endproperty
  a_b2_strobe: assert property (p_b2_strobe) else $error("B2 strobe wrong"); // R8

  property p_b1_strobe;
    @(posedge LINE_CLK_I) disable iff (!RESET_N_I)
    slot == scr_pkg::SL_B1 |=> STROBE_TWO_O == $past(l_cfg[scr_pkg::CFG_S1]) && STROBE_TWO_O != STROBE_ONE_O;
  endproperty
  a_b1_strobe: assert property (p_b1_strobe) else $error("B1 strobe wrong"); // R9

  property p_b2_third_off;
    @(posedge LINE_CLK_I) disable iff (!RESET_N_I)
    (slot == scr_pkg::SL_B2 && l_cfg[scr_pkg::CFG_B2 +: 2] == scr_pkg::ROUTE_THREE && l_cfg[scr_pkg::CFG_C3])
    |=> SER_TX_STB_O == 3'h0 && !LINE_TRANSMIT_DATA_OE_O;
  endproperty
  a_b2_third_off: assert property (p_b2_third_off) else $error("B2 went to detached controller"); // R10

  property p_idle_hiz;
    @(posedge LINE_CLK_I) disable iff (!RESET_N_I)
    slot == scr_pkg::SL_NONE |=> !LINE_TRANSMIT_DATA_OE_O;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz) else $error("driven outside frame"); // R19

  property p_direct_one;
    @(posedge MCLK_I) disable iff (!RESET_N_I)
    $changed(INTERFACE_MODE_SELECT_I) |=> SER1_DIRECT_O == ($past(INTERFACE_MODE_SELECT_I) == 2'h0);
  endproperty
  a_direct_one: assert property (p_direct_one) else $error("direct mode flag wrong"); // R15

endmodule
`default_nettype wire

// ===== pkg/scr_pkg.sv
`default_nettype none
package scr_pkg;
  // ****************************************
  // Line frame layout
  // ****************************************
  localparam logic [4:0] FRAME_BITS = 5'h14;
  localparam logic [4:0] B1_FIRST = 5'h00;
  localparam logic [4:0] B1_LAST = 5'h07;
  localparam logic [4:0] D_FIRST = 5'h08;
  localparam logic [4:0] AUX_POS = 5'h09;
  localparam logic [4:0] B2_FIRST = 5'h0a;
  localparam logic [4:0] B2_LAST = 5'h11;
  localparam logic [4:0] D_SECOND = 5'h12;
  localparam logic [4:0] MAINT_POS = 5'h13;
  localparam logic [7:0] OPEN_FLAG = 8'h7e;
  localparam logic [3:0] FLAG_BITS = 4'h8;
  // ****************************************
  // Configuration vector
  // ****************************************
  localparam logic [1:0] MODE_DIRECT = 2'h0;
  localparam logic [1:0] ROUTE_ONE = 2'h1;
  localparam logic [1:0] ROUTE_TWO = 2'h2;
  localparam logic [1:0] ROUTE_THREE = 2'h3;
  localparam int CFG_W = 12;
  localparam int CFG_MODE = 0;
  localparam int CFG_C2 = 2;
  localparam int CFG_C3 = 3;
  localparam int CFG_D = 4;
  localparam int CFG_B1 = 6;
  localparam int CFG_B2 = 8;
  localparam int CFG_S1 = 10;
  localparam int CFG_S2 = 11;
  localparam logic [11:0] CFG_RST = 12'h000;
  typedef enum logic [2:0] {
    SL_B1 = 3'h0, SL_B2 = 3'h1, SL_D = 3'h2, SL_MAINT = 3'h3, SL_AUX = 3'h4, SL_NONE = 3'h5
  } scr_slot_type;
  typedef enum logic [1:0] {
    D_IDLE = 2'b00, D_REQ = 2'b01, D_SEND = 2'b11, D_HOLD = 2'b10
  } scr_dstate_type;
  function automatic scr_slot_type slot_of(input logic [4:0] p);
    scr_slot_type s;
    s = SL_NONE;
    if (p <= B1_LAST) s = SL_B1;
    else if (p >= B2_FIRST && p <= B2_LAST) s = SL_B2;
    else if (p == D_FIRST || p == D_SECOND) s = SL_D;
    else if (p == AUX_POS) s = SL_AUX;
    else if (p == MAINT_POS) s = SL_MAINT;
    return s;
  endfunction
  function automatic logic [2:0] route_onehot(input logic [1:0] code, input logic c2,
                                              input logic c3, input logic muxed);
    logic [2:0] o;
    o = 3'h0;
    if (muxed) begin
      if (code == ROUTE_ONE) o = 3'h1;
      else if (code == ROUTE_TWO && !c2) o = 3'h2;
      else if (code == ROUTE_THREE && !c3) o = 3'h4;
    end
    return o;
  endfunction
endpackage
`default_nettype wire

// ===== verification/scr_router_test.sv
`timescale 1ns/1ps
`default_nettype none
module scr_router_test;
  typedef struct {
    logic [1:0] mode;
    logic c2, c3;
    logic [1:0] b1, b2;
    logic st1, st2;
    int tx0, tx1, tx2, oe, sa, sb;
  } scr_row_type;
  logic MCLK_I = 1'h0;
  logic RESET_N_I, LINE_CLK_I, LINE_FRAME_SYNC_I, LINE_RECEIVE_DATA_I, LINE_TRANSMIT_DATA_O;
  logic LINE_TRANSMIT_DATA_OE_O, D_CHANNEL_REQUEST_O, D_CHANNEL_GRANT_I, STROBE_ONE_O, STROBE_TWO_O;
  logic SECOND_CONTROLLER_CONNECT_I, THIRD_CONTROLLER_CONNECT_I, B1_STROBE_STEER_I, B2_STROBE_STEER_I;
  logic PORT_A_SER2_SEL_I, PORT_A_SER3_SEL_I, D_TX_PENDING_I, D_TX_EARLY_BUF_I, D_RETRANSMIT_O, D_ABORT_O;
  logic SER1_DIRECT_O, PORT_A_SER2_O, PORT_A_SER3_O, grant_req, line_w, d_bit, d_bit2, RX_BIT_O;
  logic [1:0] INTERFACE_MODE_SELECT_I, D_ROUTE_FIELD_I, B1_ROUTE_FIELD_I, B2_ROUTE_FIELD_I;
  logic [1:0] MGMT_TXD_I, MGMT_TX_STB_O, MGMT_RX_STB_O;
  logic [2:0] SER_TXD_I, SER_TX_STB_O, SER_RX_STB_O;
  int n_fail = 0, samples_checked = 0, n_retx = 0, n_abort = 0, i;
  int oe_n, s1_n, s2_n, tx_n[3], mg_n[2], rx_n, rxm_n;
  scr_row_type rows[5] = '{
    '{2'h0, 1'h0, 1'h0, 2'h1, 2'h1, 1'h0, 1'h0, 0, 0, 0, 0, 0, 0},
    '{2'h1, 1'h0, 1'h0, 2'h1, 2'h2, 1'h0, 1'h0, 8, 8, 0, 18, 8, 8},
    '{2'h2, 1'h0, 1'h0, 2'h3, 2'h3, 1'h1, 1'h0, 0, 0, 16, 18, 0, 16},
    '{2'h3, 1'h1, 1'h1, 2'h2, 2'h3, 1'h0, 1'h1, 0, 0, 0, 2, 16, 0},
    '{2'h1, 1'h0, 1'h1, 2'h2, 2'h0, 1'h0, 1'h0, 0, 8, 0, 10, 8, 8}};

  scr_router scr_router_i (.MCLK_I, .RESET_N_I, .LINE_CLK_I, .LINE_FRAME_SYNC_I, .LINE_RECEIVE_DATA_I,
    .LINE_TRANSMIT_DATA_O, .LINE_TRANSMIT_DATA_OE_O, .D_CHANNEL_REQUEST_O, .D_CHANNEL_GRANT_I,
    .STROBE_ONE_O, .STROBE_TWO_O, .INTERFACE_MODE_SELECT_I, .SECOND_CONTROLLER_CONNECT_I,
    .THIRD_CONTROLLER_CONNECT_I, .D_ROUTE_FIELD_I, .B1_ROUTE_FIELD_I, .B2_ROUTE_FIELD_I,
    .B1_STROBE_STEER_I, .B2_STROBE_STEER_I, .PORT_A_SER2_SEL_I, .PORT_A_SER3_SEL_I, .D_TX_PENDING_I,
    .D_TX_EARLY_BUF_I, .D_RETRANSMIT_O, .D_ABORT_O, .SER1_DIRECT_O, .PORT_A_SER2_O, .PORT_A_SER3_O,
    .SER_TXD_I, .SER_TX_STB_O, .SER_RX_STB_O, .MGMT_TXD_I, .MGMT_TX_STB_O, .MGMT_RX_STB_O,
    .RX_BIT_O);

  scr_xcvr_model scr_xcvr_model_i (.grant_req_i(grant_req), .txd_i(LINE_TRANSMIT_DATA_O),
    .txd_oe_i(LINE_TRANSMIT_DATA_OE_O), .line_clk_o(LINE_CLK_I), .sync_o(LINE_FRAME_SYNC_I),
    .rxd_o(LINE_RECEIVE_DATA_I), .grant_o(D_CHANNEL_GRANT_I), .line_o(line_w));

  always #25 MCLK_I = ~MCLK_I;

  // Pulses looked at mid-cycle, clear of their launch edge
  always @(negedge MCLK_I) begin
    if (D_RETRANSMIT_O === 1'h1) n_retx++;
    if (D_ABORT_O === 1'h1) n_abort++;
  end

  // ****************************************
  // Compare and report
  // ****************************************
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_cnt(input string name, input int exp, input int got);
    samples_checked++;
    if (got != exp) begin
      n_fail++;
      $display("wrong value %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  // Counts one whole line frame, starting at the next sync edge
  task automatic run_frame();
    int n;
    int k;
    oe_n = 0;
    s1_n = 0;
    s2_n = 0;
    tx_n = '{0, 0, 0};
    mg_n = '{0, 0};
    rx_n = 0;
    rxm_n = 0;
    n = 0;
    do begin
      @(posedge LINE_CLK_I);
      n++;
    end while (LINE_FRAME_SYNC_I !== 1'h1 && n < 60);
    if (n >= 60) begin
      n_fail++;
      $display("wrong value frame_sync expected 1 seen 0");
      tally_and_finish();
    end
    for (k = 0; k < 20; k++) begin
      #1;
      oe_n += (LINE_TRANSMIT_DATA_OE_O === 1'h1);
      s1_n += (STROBE_ONE_O === 1'h1);
      s2_n += (STROBE_TWO_O === 1'h1);
      for (n = 0; n < 3; n++) tx_n[n] += (SER_TX_STB_O[n] === 1'h1);
      for (n = 0; n < 2; n++) mg_n[n] += (MGMT_TX_STB_O[n] === 1'h1);
      rx_n += $countones(SER_RX_STB_O) + $countones(MGMT_RX_STB_O);
      rxm_n += (RX_BIT_O !== LINE_RECEIVE_DATA_I);
      if (k == 8) d_bit = line_w;
      if (k == 18) d_bit2 = line_w;
      @(posedge LINE_CLK_I);
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    RESET_N_I = 1'h0;
    grant_req = 1'h0;
    INTERFACE_MODE_SELECT_I = 2'h0;
    SECOND_CONTROLLER_CONNECT_I = 1'h0;
    THIRD_CONTROLLER_CONNECT_I = 1'h0;
    D_ROUTE_FIELD_I = 2'h0;
    B1_ROUTE_FIELD_I = 2'h0;
    B2_ROUTE_FIELD_I = 2'h0;
    B1_STROBE_STEER_I = 1'h0;
    B2_STROBE_STEER_I = 1'h0;
    PORT_A_SER2_SEL_I = 1'h1;
    PORT_A_SER3_SEL_I = 1'h1;
    D_TX_PENDING_I = 1'h0;
    D_TX_EARLY_BUF_I = 1'h0;
    SER_TXD_I = 3'h2;
    MGMT_TXD_I = 2'h1;
    repeat (2) @(posedge MCLK_I);
    repeat (2) @(posedge LINE_CLK_I);
    #1;
    chk_bit("oe_in_reset", 1'h0, LINE_TRANSMIT_DATA_OE_O);
    chk_bit("request_in_reset", 1'h0, D_CHANNEL_REQUEST_O);
    @(negedge MCLK_I);
    RESET_N_I = 1'h1;
    $display("reset test done");
    for (i = 0; i < 5; i++) begin
      @(negedge MCLK_I);
      INTERFACE_MODE_SELECT_I = rows[i].mode;
      SECOND_CONTROLLER_CONNECT_I = rows[i].c2;
      THIRD_CONTROLLER_CONNECT_I = rows[i].c3;
      B1_ROUTE_FIELD_I = rows[i].b1;
      B2_ROUTE_FIELD_I = rows[i].b2;
      B1_STROBE_STEER_I = rows[i].st1;
      B2_STROBE_STEER_I = rows[i].st2;
      run_frame();
      run_frame();
      chk_bit("ser1_direct", rows[i].mode == 2'h0, SER1_DIRECT_O);
      chk_bit("port_a_ser2", rows[i].c2, PORT_A_SER2_O);
      chk_bit("port_a_ser3", rows[i].c3, PORT_A_SER3_O);
      chk_cnt("tx_stb_one", rows[i].tx0, tx_n[0]);
      chk_cnt("tx_stb_two", rows[i].tx1, tx_n[1]);
      chk_cnt("tx_stb_three", rows[i].tx2, tx_n[2]);
      chk_cnt("oe_bits", rows[i].oe, oe_n);
      chk_cnt("mgmt_maint", rows[i].mode != 2'h0, mg_n[0]);
      chk_cnt("mgmt_aux", rows[i].mode != 2'h0, mg_n[1]);
      chk_cnt("rx_strobes", rows[i].oe, rx_n);
      chk_cnt("rx_bit_mismatches", 0, rxm_n);
      if (rows[i].mode != 2'h0) begin
        chk_cnt("strobe_one", rows[i].sa, s1_n);
        chk_cnt("strobe_two", rows[i].sb, s2_n);
      end
      $display("routing row %0d done", i);
    end
    @(negedge MCLK_I);
    INTERFACE_MODE_SELECT_I = 2'h1;
    B1_ROUTE_FIELD_I = 2'h0;
    B2_ROUTE_FIELD_I = 2'h0;
    D_ROUTE_FIELD_I = 2'h1;
    D_TX_PENDING_I = 1'h1;
    D_TX_EARLY_BUF_I = 1'h1;
    run_frame();
    chk_bit("request", 1'h1, D_CHANNEL_REQUEST_O);
    // Grant pulse that misses the sync edge
    repeat (5) @(posedge LINE_CLK_I);
    grant_req = 1'h1;
    repeat (8) @(posedge LINE_CLK_I);
    grant_req = 1'h0;
    run_frame();
    chk_cnt("oe_bits_no_grant", 2, oe_n);
    grant_req = 1'h1;
    run_frame();
    chk_cnt("oe_bits_granted", 4, oe_n);
    chk_bit("first_d_bit", 1'h0, d_bit);
    chk_bit("second_d_bit", 1'h1, d_bit2);
    $display("grant test done");
    grant_req = 1'h0;
    run_frame();
    chk_cnt("retransmit", 1, n_retx);
    chk_cnt("abort", 0, n_abort);
    chk_bit("request_after_collision", 1'h1, D_CHANNEL_REQUEST_O);
    grant_req = 1'h1;
    run_frame();
    chk_bit("resent_first_d_bit", 1'h0, d_bit);
    @(negedge MCLK_I);
    D_TX_EARLY_BUF_I = 1'h0;
    grant_req = 1'h0;
    run_frame();
    chk_cnt("abort", 1, n_abort);
    chk_cnt("retransmit", 1, n_retx);
    chk_bit("request_after_abort", 1'h0, D_CHANNEL_REQUEST_O);
    @(negedge MCLK_I);
    D_TX_PENDING_I = 1'h0;
    run_frame();
    chk_bit("request_idle", 1'h0, D_CHANNEL_REQUEST_O);
    $display("collision test done");
    @(negedge MCLK_I);
    RESET_N_I = 1'h0;
    PORT_A_SER3_SEL_I = 1'h0;
    repeat (2) @(posedge LINE_CLK_I);
    #1;
    chk_bit("direct_in_reset", 1'h0, SER1_DIRECT_O);
    chk_bit("strobe_in_reset", 1'h0, STROBE_ONE_O | STROBE_TWO_O);
    @(negedge MCLK_I);
    RESET_N_I = 1'h1;
    run_frame();
    run_frame();
    chk_cnt("oe_bits_after_reset", 2, oe_n);
    chk_bit("port_a_ser3_gpio", 1'h0, PORT_A_SER3_O);
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ===== verification/scr_xcvr_model.sv
`timescale 1ns/1ps
`default_nettype none
module scr_xcvr_model (
  input wire logic grant_req_i,
  input wire logic txd_i,
  input wire logic txd_oe_i,
  output logic line_clk_o,
  output logic sync_o,
  output logic rxd_o,
  output logic grant_o,
  output logic line_o
);
  int bit_r;
  // ****************************************
  // Line clock, offset from the master clock
  // ****************************************
  initial begin
    line_clk_o = 1'h0;
    sync_o = 1'h0;
    rxd_o = 1'h1;
    grant_o = 1'h0;
    bit_r = 15;
    #7;
    forever #80 line_clk_o = ~line_clk_o;
  end
  // ****************************************
  // Frame timing and grant
  // ****************************************
  // sync heads twenty bits
  always @(negedge line_clk_o) begin
    bit_r = (bit_r == 19) ? 0 : bit_r + 1;
    sync_o <= (bit_r == 0);
    rxd_o <= ~rxd_o;
  end
  always @(negedge line_clk_o) begin
    grant_o <= grant_req_i;
  end
  // Pull-up holds the wire high when released
  assign line_o = txd_oe_i ? txd_i : 1'h1;
endmodule
`default_nettype wire
